// *** rtl/cds_slave.sv ***
// dac setting two-wire slave: volatile setting, nonvolatile copy, write protect
// assumes link pins are asynchronous to mclk and far slower (400 kHz at most)
`include "cds_consts.svh"
module cds_slave #(
  parameter int              PROG_CYCLES = `CDS_PROG_CYC,
  parameter logic [6:0]      NV_INIT     = `CDS_NV_RST
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  // serial link
  cds_if.device              bus,
  // write protect pins
  input  wire logic          wp_n_pin,
  output wire logic          wp_p_out,
  // setting and store
  output logic [6:0]         current_step_value,
  output logic [6:0]         nv_value,
  output wire logic          prog_busy
);

  localparam int PW = $clog2(PROG_CYCLES + 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  // bit 3 protect, 2 test clock, 1 serial clock, 0 serial data
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta <= 4'hf;
      pin_sync <= 4'hf;
    end else begin
      pin_meta <= {wp_n_pin, bus.scl_s, bus.scl, bus.sda};
      pin_sync <= pin_meta;
    end
  end

  logic wp_s;
  logic scl_eff;
  logic sda_s;

  assign wp_s    = pin_sync[3];
  // closed switch hands the clock over to the test input
  assign scl_eff = wp_s ? pin_sync[2] : pin_sync[1];
  assign sda_s   = pin_sync[0];

  // pure inversion so it follows the pin even in reset
  assign wp_p_out = ~wp_n_pin;

  // ****************************************
  // link state
  // ****************************************
  cds_pkg::cds_dev_state_t state;
  cds_pkg::cds_dev_state_t next_state;
  logic          prev_scl;
  logic          prev_sda;
  logic [2:0]    bit_cnt;
  logic [2:0]    next_bit_cnt;
  logic [7:0]    shift;
  logic [7:0]    next_shift;
  logic          byte_full;
  logic          next_byte_full;
  logic          rw;
  logic          next_rw;
  logic          sda_low;
  logic          next_sda_low;
  logic [6:0]    setting;
  logic [6:0]    next_setting;
  logic [6:0]    nv_store;
  logic [6:0]    next_nv_store;
  logic [PW-1:0] prog_cnt;
  logic [PW-1:0] next_prog_cnt;

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic read_pbit;

  // device never drives the clock: it only follows the master's edges
  assign scl_rise = scl_eff & ~prev_scl;
  assign scl_fall = ~scl_eff & prev_scl;
  assign start_ev = scl_eff & prev_scl & prev_sda & ~sda_s;
  assign stop_ev  = scl_eff & prev_scl & ~prev_sda & sda_s;

  assign prog_busy = (prog_cnt != '0);
  assign read_pbit = prog_busy ? `CDS_PBIT_BUSY : `CDS_PBIT_READY;

  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shift     = shift;
    next_byte_full = byte_full;
    next_rw        = rw;
    next_sda_low   = sda_low;
    next_setting   = setting;
    next_nv_store  = nv_store;
    next_prog_cnt  = prog_cnt;

    // store programming time runs regardless of bus activity
    if (prog_busy) begin
      next_prog_cnt = prog_cnt - 1'b1;
    end

    unique case (state)
      cds_pkg::DS_BOOT: begin
        next_setting = nv_store;
        next_state   = cds_pkg::DS_IDLE;
      end
      cds_pkg::DS_IDLE: begin
        next_sda_low = 1'b0;
      end
      cds_pkg::DS_ADDR: begin
        if (scl_rise) begin
          next_shift   = {shift[6:0], sda_s};
          next_bit_cnt = bit_cnt + 1'b1;
          if (bit_cnt == `CDS_LAST_BIT) begin
            next_byte_full = 1'b1;
          end
        end
        if (scl_fall && byte_full) begin
          next_byte_full = 1'b0;
          if (shift[7:1] == `CDS_ADDR7) begin
            next_rw      = shift[0];
            next_sda_low = 1'b1;
            next_state   = cds_pkg::DS_ADDR_ACK;
          end else begin
            next_state = cds_pkg::DS_IGNORE;
          end
        end
      end
      cds_pkg::DS_ADDR_ACK: begin
        // low since the previous fall, held until this fall, which releases it (write) or puts out the first read bit (read)
        if (scl_fall) begin
          next_bit_cnt = '0;
          if (rw == `CDS_RW_READ) begin
            next_shift   = {setting[5:0], read_pbit, 1'b0};
            next_sda_low = ~setting[6];
            next_state   = cds_pkg::DS_READ;
          end else begin
            next_sda_low = 1'b0;
            next_state   = cds_pkg::DS_WRITE;
          end
        end
      end
      cds_pkg::DS_WRITE: begin
        if (scl_rise) begin
          next_shift   = {shift[6:0], sda_s};
          next_bit_cnt = bit_cnt + 1'b1;
          if (bit_cnt == `CDS_LAST_BIT) begin
            next_byte_full = 1'b1;
          end
        end
        if (scl_fall && byte_full) begin
          next_byte_full = 1'b0;
          next_sda_low   = 1'b1;
          next_state     = cds_pkg::DS_WRITE_ACK;
          // register always takes the byte, even when the store cannot
          next_setting   = shift[7:1];
          // a store write during a running program is dropped, not queued
          if (shift[0] == `CDS_PBIT_NV && wp_s && !prog_busy) begin
            next_nv_store = shift[7:1];
            next_prog_cnt = PW'(PROG_CYCLES);
          end
        end
      end
      cds_pkg::DS_WRITE_ACK: begin
        if (scl_fall) begin
          next_sda_low = 1'b0;
          next_bit_cnt = '0;
          next_state   = cds_pkg::DS_WRITE;
        end
      end
      cds_pkg::DS_READ: begin
        if (scl_rise) begin
          next_bit_cnt = bit_cnt + 1'b1;
          if (bit_cnt == `CDS_LAST_BIT) begin
            next_byte_full = 1'b1;
          end
        end
        if (scl_fall) begin
          if (byte_full) begin
            next_byte_full = 1'b0;
            next_sda_low   = 1'b0;
            next_state     = cds_pkg::DS_READ_ACK;
          end else begin
            next_sda_low = ~shift[7];
            next_shift   = {shift[6:0], 1'b0};
          end
        end
      end
      cds_pkg::DS_READ_ACK: begin
        // a released line on the ack clock means the master is done
        if (scl_rise && sda_s) begin
          next_state = cds_pkg::DS_IGNORE;
        end else if (scl_fall) begin
          next_bit_cnt = '0;
          next_shift   = {setting[5:0], read_pbit, 1'b0};
          next_sda_low = ~setting[6];
          next_state   = cds_pkg::DS_READ;
        end
      end
      cds_pkg::DS_IGNORE: begin
        next_sda_low = 1'b0;
      end
      default: begin
        next_sda_low = 1'b0;
        next_state   = cds_pkg::DS_IDLE;
      end
    endcase

    // bus conditions override any byte in progress
    if (state != cds_pkg::DS_BOOT) begin
      if (stop_ev) begin
        next_sda_low   = 1'b0;
        next_byte_full = 1'b0;
        next_state     = cds_pkg::DS_IDLE;
      end else if (start_ev) begin
        next_sda_low   = 1'b0;
        next_byte_full = 1'b0;
        next_bit_cnt   = '0;
        next_state     = cds_pkg::DS_ADDR;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= cds_pkg::DS_BOOT;
      prev_scl  <= 1'b1;
      prev_sda  <= 1'b1;
      bit_cnt   <= '0;
      shift     <= '0;
      byte_full <= 1'b0;
      rw        <= 1'b0;
      sda_low   <= 1'b0;
      setting   <= '0;
      nv_store  <= NV_INIT;
      prog_cnt  <= '0;
    end else begin
      state     <= next_state;
      prev_scl  <= scl_eff;
      prev_sda  <= sda_s;
      bit_cnt   <= next_bit_cnt;
      shift     <= next_shift;
      byte_full <= next_byte_full;
      rw        <= next_rw;
      sda_low   <= next_sda_low;
      setting   <= next_setting;
      nv_store  <= next_nv_store;
      prog_cnt  <= next_prog_cnt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bus.d_sda_o        = 1'b0;
  assign bus.d_sda_oe       = sda_low;
  assign current_step_value = setting;
  assign nv_value           = nv_store;

endmodule

// *** rtl/cds_consts.svh ***
// constants for the dac setting two-wire slave and its bus master
// assumes a 100 MHz system clock and a standard-mode/fast-mode serial bus
`ifndef CDS_CONSTS_SVH
`define CDS_CONSTS_SVH

// ****************************************
// serial bus
// ****************************************
`define CDS_ADDR7        7'h4f
`define CDS_SET_W        7
`define CDS_STEPS        128
`define CDS_LAST_BIT     3'h7
`define CDS_RW_READ      1'b1
`define CDS_PBIT_REG     1'b1
`define CDS_PBIT_NV      1'b0
`define CDS_PBIT_READY   1'b1
`define CDS_PBIT_BUSY    1'b0
`define CDS_NV_RST       7'h40

// ****************************************
// timing
// ****************************************
`define CDS_CLK_HZ       100000000
`define CDS_PROG_TIME_MS 200
`define CDS_PROG_CYC     ((`CDS_CLK_HZ / 1000) * `CDS_PROG_TIME_MS)
`define CDS_SCL_MAX_HZ   400000
`define CDS_QTR_CYC      ((`CDS_CLK_HZ + 4 * `CDS_SCL_MAX_HZ - 1) / (4 * `CDS_SCL_MAX_HZ))

// ****************************************
// master control registers (apb)
// ****************************************
`define CDS_OFS_CTRL     8'h00
`define CDS_OFS_DATA     8'h04
`define CDS_OFS_STAT     8'h08
`define CDS_OFS_RDAT     8'h0c
`define CDS_CTRL_GO      0
`define CDS_CTRL_RW      1
`define CDS_CTRL_PBIT    2
`define CDS_CTRL_REL     3
`define CDS_STAT_BUSY    0
`define CDS_STAT_NACK    1
`define CDS_STAT_DONE    2

`endif

// *** rtl/cds_pkg.sv ***
// types shared by both ends of the dac setting serial link
// assumes nothing beyond the constants header
package cds_pkg;

  // ****************************************
  // device end states
  // ****************************************
  typedef enum logic [3:0] {
    DS_BOOT      = 4'b0000,
    DS_IDLE      = 4'b0001,
    DS_ADDR      = 4'b0010,
    DS_ADDR_ACK  = 4'b0011,
    DS_WRITE     = 4'b0100,
    DS_WRITE_ACK = 4'b0101,
    DS_READ      = 4'b0110,
    DS_READ_ACK  = 4'b0111,
    DS_IGNORE    = 4'b1000
  } cds_dev_state_t;

  // ****************************************
  // master end states
  // ****************************************
  typedef enum logic [1:0] {
    MS_IDLE  = 2'b00,
    MS_START = 2'b01,
    MS_BIT   = 2'b10,
    MS_STOP  = 2'b11
  } cds_mst_state_t;

endpackage

// *** rtl/cds_if.sv ***
// open-drain two-wire link between the bus master and the dac setting slave
// assumes pull-ups: a line is low only while some party enables a low drive
interface cds_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl_s_drv;
  logic scl;
  logic sda;
  logic scl_s;

  // wired-and of all open-drain drivers
  assign scl   = !(m_scl_oe && !m_scl_o);
  assign sda   = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);
  assign scl_s = scl_s_drv;

  modport device (input scl, input sda, input scl_s, output d_sda_o, output d_sda_oe);
  modport master (input scl, input sda, output m_scl_o, output m_scl_oe,
                  output m_sda_o, output m_sda_oe);
endinterface

// *** rtl/cds_master.sv ***
// two-wire bus master that writes or reads the dac setting, ordered over apb
// assumes the slave never stretches the clock; one data byte per transfer
`include "cds_consts.svh"
module cds_master #(
  parameter int             QTR_CYC = `CDS_QTR_CYC
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // apb slave
  input  wire logic [7:0]   paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output wire logic         pready,
  output wire logic         pslverr,
  // serial link
  cds_if.master             bus
);

  localparam int QW = $clog2(QTR_CYC + 1);

  // ****************************************
  // line synchronisers
  // ****************************************
  logic [1:0] ln_meta;
  logic [1:0] ln_sync;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ln_meta <= 2'h3;
      ln_sync <= 2'h3;
    end else begin
      ln_meta <= {bus.scl, bus.sda};
      ln_sync <= ln_meta;
    end
  end

  // ****************************************
  // registers and engine
  // ****************************************
  cds_pkg::cds_mst_state_t state;
  cds_pkg::cds_mst_state_t next_state;
  logic [QW-1:0] qcnt;
  logic [QW-1:0] next_qcnt;
  logic [1:0]  phase;
  logic [1:0]  next_phase;
  logic [3:0]  bitn;
  logic [3:0]  next_bitn;
  logic        second;
  logic        next_second;
  logic        scl_low;
  logic        next_scl_low;
  logic        sda_low;
  logic        next_sda_low;
  logic        c_rw;
  logic        next_c_rw;
  logic        c_pbit;
  logic        next_c_pbit;
  logic        c_rel;
  logic        next_c_rel;
  logic [6:0]  c_data;
  logic [6:0]  next_c_data;
  logic        nack;
  logic        next_nack;
  logic        done;
  logic        next_done;
  logic [7:0]  rx;
  logic [7:0]  next_rx;
  logic [31:0] next_prdata;
  logic        wr_en;
  logic        tick;
  logic        mapped;
  logic [7:0]  tx;

  assign pready  = 1'b1;
  assign mapped  = (paddr == `CDS_OFS_CTRL) || (paddr == `CDS_OFS_DATA) ||
                   (paddr == `CDS_OFS_STAT) || (paddr == `CDS_OFS_RDAT);
  assign pslverr = psel & penable & ~mapped;
  assign wr_en   = psel & penable & pwrite;
  assign tick    = (qcnt == '0);
  assign tx      = second ? {c_data, c_pbit} : {`CDS_ADDR7, c_rw};

  always_comb begin
    next_state   = state;
    next_qcnt    = tick ? QW'(QTR_CYC - 1) : qcnt - 1'b1;
    next_phase   = phase;
    next_bitn    = bitn;
    next_second  = second;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_c_rw    = c_rw;
    next_c_pbit  = c_pbit;
    next_c_rel   = c_rel;
    next_c_data  = c_data;
    next_nack    = nack;
    next_done    = done;
    next_rx      = rx;
    next_prdata  = prdata;

    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CDS_OFS_CTRL: next_prdata = {28'h0, c_rel, c_pbit, c_rw, 1'b0};
        `CDS_OFS_DATA: next_prdata = {25'h0, c_data};
        `CDS_OFS_STAT: next_prdata = {29'h0, done, nack, state != cds_pkg::MS_IDLE};
        `CDS_OFS_RDAT: next_prdata = {24'h0, rx};
        default:       next_prdata = 32'h0;
      endcase
    end
    if (wr_en && paddr == `CDS_OFS_DATA) begin
      next_c_data = pwdata[6:0];
    end

    unique case (state)
      cds_pkg::MS_IDLE: begin
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
        if (wr_en && paddr == `CDS_OFS_CTRL) begin
          next_c_rw   = pwdata[`CDS_CTRL_RW];
          next_c_pbit = pwdata[`CDS_CTRL_PBIT];
          next_c_rel  = pwdata[`CDS_CTRL_REL];
          // go is dropped while the clock is handed to the test input
          // or the lines are not both high
          if (pwdata[`CDS_CTRL_GO] && !pwdata[`CDS_CTRL_REL] && ln_sync == 2'h3) begin
            next_state  = cds_pkg::MS_START;
            next_phase  = 2'h0;
            next_qcnt   = QW'(QTR_CYC - 1);
            next_nack   = 1'b0;
            next_done   = 1'b0;
            next_second = 1'b0;
            next_bitn   = 4'h0;
          end
        end
      end
      cds_pkg::MS_START: begin
        if (tick) begin
          next_phase = phase + 1'b1;
          if (phase == 2'h0) begin
            next_sda_low = 1'b1;
          end else if (phase == 2'h1) begin
            next_scl_low = 1'b1;
            next_phase   = 2'h0;
            next_state   = cds_pkg::MS_BIT;
          end
        end
      end
      cds_pkg::MS_BIT: begin
        if (tick) begin
          next_phase = phase + 1'b1;
          unique case (phase)
            2'h0: begin
              if (bitn[3] || (second && c_rw)) begin
                next_sda_low = 1'b0;
              end else begin
                next_sda_low = ~tx[3'h7 - bitn[2:0]];
              end
            end
            2'h1: next_scl_low = 1'b0;
            2'h2: begin
              if (!bitn[3]) begin
                next_rx = {rx[6:0], ln_sync[0]};
              end else if (!second) begin
                next_nack = ln_sync[0];
              end
            end
            default: begin
              next_scl_low = 1'b1;
              next_bitn    = bitn + 1'b1;
              if (bitn[3]) begin
                next_bitn = 4'h0;
                if (second || nack) begin
                  next_state = cds_pkg::MS_STOP;
                end else begin
                  next_second = 1'b1;
                end
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          next_phase = phase + 1'b1;
          unique case (phase)
            2'h0: next_sda_low = 1'b1;
            2'h1: next_scl_low = 1'b0;
            2'h2: next_sda_low = 1'b0;
            default: begin
              next_done  = 1'b1;
              next_state = cds_pkg::MS_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state   <= cds_pkg::MS_IDLE;
      qcnt    <= '0;
      phase   <= 2'h0;
      bitn    <= 4'h0;
      second  <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      c_rw    <= 1'b0;
      c_pbit  <= `CDS_PBIT_REG;
      c_rel   <= 1'b0;
      c_data  <= 7'h0;
      nack    <= 1'b0;
      done    <= 1'b0;
      rx      <= 8'h0;
      prdata  <= 32'h0;
    end else begin
      state   <= next_state;
      qcnt    <= next_qcnt;
      phase   <= next_phase;
      bitn    <= next_bitn;
      second  <= next_second;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
      c_rw    <= next_c_rw;
      c_pbit  <= next_c_pbit;
      c_rel   <= next_c_rel;
      c_data  <= next_c_data;
      nack    <= next_nack;
      done    <= next_done;
      rx      <= next_rx;
      prdata  <= next_prdata;
    end
  end

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = scl_low;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = sda_low;

endmodule

// *** testbench/cds_link_asserts.sv ***
// link checker for the dac setting slave and its bus master
// assumes resolved line levels and drive enables of one cds_if
module cds_link_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // link
  input wire logic m_sda_oe,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q, sda_q, match, rw;
  logic       next_match, next_rw;
  logic [3:0] bc, next_bc;
  logic [1:0] nb, next_nb;
  logic [7:0] sh, next_sh;
  logic [10:0] oc, next_oc;
  wire        rise  = scl && !scl_q;
  wire        start = scl && scl_q && sda_q && !sda;
  wire        stop  = scl && scl_q && !sda_q && sda;

  // ****
  // frame tracker
  // ****
  always_comb begin
    next_bc = bc;
    next_nb = nb;
    next_sh = sh;
    next_match = match;
    next_rw = rw;
    next_oc = (oc != 11'h0) ? oc + 11'h1 : oc;
    if (rise) begin
      next_bc = (bc == 4'h8) ? 4'h0 : bc + 4'h1;
      if (bc == 4'h8 && nb != 2'h3) next_nb = nb + 2'h1;
      if (bc < 4'h8) next_sh = {sh[6:0], sda};
      if (bc == 4'h7 && nb == 2'h0) next_match = ({sh[6:0], 1'b0} == 8'h9e);
      if (bc == 4'h8 && nb == 2'h0) next_rw = sh[0];
    end
    // a repeated start restarts the count; none is sent here
    if (start || stop) begin
      next_bc = 4'h0;
      next_nb = 2'h0;
      next_match = 1'b0;
    end
    // frame age in cycles since start, closed by stop
    if (start) next_oc = 11'h1;
    if (stop) next_oc = 11'h0;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {scl_q, sda_q, match, rw, bc, nb, sh} <= {4'hc, 4'h0, 2'h0, 8'h00};
      oc <= 11'h0;
    end else begin
      {scl_q, sda_q, match, rw} <= {scl, sda, next_match, next_rw};
      {bc, nb, sh} <= {next_bc, next_nb, next_sh};
      oc <= next_oc;
    end
  end

  // ****
  // properties
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_addr_sent: assert property (rise && nb == 2'h0 && bc == 4'h8 |-> match)
    else $error("address byte is not ours");
  chk_addr_ack: assert property (rise && nb == 2'h0 && bc == 4'h8 && match |-> !sda)
    else $error("own address not acknowledged");
  chk_data_ack: assert property (rise && nb == 2'h1 && bc == 4'h8 && !rw |-> !sda)
    else $error("written byte not acknowledged");
  chk_read_nack: assert property (rise && nb == 2'h1 && bc == 4'h8 && rw |-> sda)
    else $error("read byte not closed by nack");
  chk_read_free: assert property (rise && nb == 2'h1 && bc < 4'h8 && rw |-> !m_sda_oe)
    else $error("master drives data during read");
  chk_ack_hold: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("slave data moved while clock high");
  chk_quiet_other: assert property (!match |-> !d_sda_oe)
    else $error("slave drives data when not selected");
  chk_start_clock: assert property (start |-> ##[1:40] !scl)
    else $error("no clock after start");
  // counted, since a frame may stay open longer than a delay range may span
  chk_stop_close: assert property (oc <= 11'h4b0)
    else $error("transfer not closed by stop");

  cover property (rise && nb == 2'h1 && bc == 4'h8 && !rw);
  cover property (rise && nb == 2'h1 && bc == 4'h8 && rw);
  cover property (start);
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench: apb-driven master against the slave, plus a
// bit-banged second link for a foreign address and for own-address writes over the test clock input
// assumes the design files and cds_consts.svh are compiled first
`include "cds_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, wp_p_out, prog_busy;
  logic        wp_n_pin = 1'b0;
  logic        wp_b = 1'b0;
  logic        scl_b_s = 1'b1;
  logic [6:0]  current_step_value, nv_value, set_b, cur;
  logic [6:0]  q_set[$];
  logic [6:0]  q_nv[$];
  int          err_count = 0;
  int          tests_run = 0;
  int          i;
  cds_if bus_a();
  cds_if bus_b();

  always #5 mclk = ~mclk;
  // test input mirrors the master's clock while protect is high
  assign bus_a.scl_s_drv = wp_n_pin ? bus_a.scl : 1'b1;
  assign bus_b.scl_s_drv = scl_b_s;
  assign bus_b.m_scl_o = 1'b0;
  assign bus_b.m_sda_o = 1'b0;

  cds_master #(.QTR_CYC(5)) i_cds_master (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(bus_a));
  cds_slave #(.PROG_CYCLES(2000)) i_cds_slave (.mclk(mclk), .sys_rst(sys_rst), .bus(bus_a),
    .wp_n_pin(wp_n_pin), .wp_p_out(wp_p_out), .current_step_value(current_step_value),
    .nv_value(nv_value), .prog_busy(prog_busy));
  cds_slave #(.PROG_CYCLES(2000)) i_cds_slave_b (.mclk(mclk), .sys_rst(sys_rst), .bus(bus_b),
    .wp_n_pin(wp_b), .wp_p_out(), .current_step_value(set_b), .nv_value(), .prog_busy());
  cds_link_asserts i_cds_link_asserts (.mclk(mclk), .sys_rst(sys_rst),
    .m_sda_oe(bus_a.m_sda_oe), .d_sda_oe(bus_a.d_sda_oe), .scl(bus_a.scl), .sda(bus_a.sda));

  // ****
  // checking
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task tally_and_finish;
    $display("%0d mismatches in %0d comparisons", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // an empty queue yields x, so an unexpected change always mismatches
  always @(current_step_value) if (sys_rst === 1'b0)
    chk(32'(current_step_value), q_set.size() ? 32'(q_set.pop_front()) : 'x, "setting");
  always @(nv_value) if (sys_rst === 1'b0)
    chk(32'(nv_value), q_nv.size() ? 32'(q_nv.pop_front()) : 'x, "stored");

  // ****
  // drivers
  // ****
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task xfer(input logic r, input logic pb, input logic [6:0] d);
    apb(1'b1, `CDS_OFS_DATA, {25'h0, d});
    apb(1'b1, `CDS_OFS_CTRL, {29'h0, pb, r, 1'b1});
    do apb(1'b0, `CDS_OFS_STAT, 32'h0); while (rd[2] !== 1'b1);
    chk(32'(rd[1]), 32'h0, "nack");
  endtask

  task wr(input logic pb, input logic nv);
    cur = cur ^ 7'($urandom_range(1, 127));
    q_set.push_back(cur);
    if (nv) q_nv.push_back(cur);
    xfer(1'b0, pb, cur);
  endtask

  task rdb(input logic pb);
    xfer(1'b1, 1'b0, 7'h00);
    apb(1'b0, `CDS_OFS_RDAT, 32'h0);
    chk(rd, {24'h0, cur, pb}, "read back");
  endtask

  task bb(input logic s, input logic c);
    @(posedge mclk);
    bus_b.m_sda_oe <= !s;
    // with protect high the clock travels over the test input only
    bus_b.m_scl_oe <= !c && !wp_b;
    scl_b_s <= c || !wp_b;
    repeat (5) @(posedge mclk);
  endtask

  task frame(input logic [7:0] a, input logic [7:0] d, input logic ack);
    logic [15:0] s;
    logic        b;
    s = {a, d};
    bb(1'b0, 1'b1);
    for (int k = 0; k < 18; k++) begin
      b = (k % 9 == 8) ? 1'b1 : s[15 - 8 * (k / 9) - k % 9];
      bb(b, 1'b0);
      bb(b, 1'b1);
      if (k % 9 == 8) chk(32'(bus_b.sda), 32'(!ack), "ack");
    end
    bb(1'b0, 1'b0);
    bb(1'b0, 1'b1);
    bb(1'b1, 1'b1);
  endtask

  // ****
  // scenarios
  // ****
  initial begin
    bus_b.m_scl_oe = 1'b0;
    bus_b.m_sda_oe = 1'b0;
    void'($urandom(32'h521c));
    cur = `CDS_NV_RST;
    q_set.push_back(cur);
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(32'(wp_p_out), 32'h1, "protect out");
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], er}, 32'h1, "unmapped");
    // go while the clock is handed over must not start a transfer
    apb(1'b1, `CDS_OFS_CTRL, 32'h9);
    apb(1'b0, `CDS_OFS_STAT, 32'h0);
    chk(rd, 32'h0, "released go");
    wr(1'b1, 1'b0);
    rdb(1'b1);
    wr(1'b0, 1'b0);
    rdb(1'b1);
    wp_n_pin <= 1'b1;
    @(posedge mclk);
    chk(32'(wp_p_out), 32'h0, "protect out");
    wr(1'b0, 1'b1);
    chk(32'(prog_busy), 32'h1, "busy");
    rdb(1'b0);
    // store write during programming only reaches the register
    wr(1'b0, 1'b0);
    for (i = 0; i < 3000 && prog_busy !== 1'b0; i++) @(posedge mclk);
    rdb(1'b1);
    chk(32'(q_set.size() + q_nv.size()), 32'h0, "pending");
    frame(8'ha0, 8'h55, 1'b0);
    chk(32'(set_b), 32'(`CDS_NV_RST), "foreign");
    wp_b <= 1'b1;
    frame(8'h9e, 8'h2b, 1'b1);
    chk(32'(set_b), 32'h15, "second link");
    tally_and_finish;
  end

  // transfers take a few hundred cycles each; this leaves wide margin
  initial begin
    repeat (50000) @(posedge mclk);
    err_count++;
    tally_and_finish;
  end
endmodule
